// ---- hdl/pbas_cfg.svh ----
/*
 * Constants of the port buffer and analog input select block:
 * register indexes, field positions, reset values and bus widths.
 * Assumes it is included by bare name from the modules and the testbench.
 */
`ifndef PBAS_CFG_SVH
`define PBAS_CFG_SVH

// Register indexes; byte address is four times the index
`define PBAS_IDX_PIN_LEVELS   16'hFFD0
`define PBAS_IDX_ANALOG_SEL   16'hFFEF
`define PBAS_IDX_DIRECTION    16'hFFF0
`define PBAS_IDX_OUT_VALUE    16'hFFF1
`define PBAS_IDX_FUNCTION     16'hFFF2
`define PBAS_IDX_SERIAL_CTRL  16'hFFF3
`define PBAS_IDX_STD_LEVELS   16'hFFF4

// Bus and port widths
`define PBAS_ADDR_W           18
`define PBAS_DATA_W           32
`define PBAS_PORT_W           8

// Reset values
`define PBAS_RST_ANALOG_SEL   8'h00
`define PBAS_RST_DIRECTION    8'h00
`define PBAS_RST_OUT_VALUE    8'h00
`define PBAS_RST_FUNCTION     8'h00
`define PBAS_RST_SERIAL_CTRL  2'h0

// Build-time pull-up choice per standard pin
`define PBAS_PULLUP_OPTION    8'h00

// Serial control fields and serial clock pin positions
`define PBAS_SER_EXT1_BIT     0
`define PBAS_SER_EXT2_BIT     1
`define PBAS_SER_CLK1_POS     1
`define PBAS_SER_CLK2_POS     4

// AXI4-Lite response codes
`define PBAS_RESP_OKAY        2'h0
`define PBAS_RESP_SLVERR      2'h2

`endif

// ---- hdl/pbas_pkg.sv ----
/*
 * Types of the port buffer and analog input select block.
 * Assumes pbas_cfg.svh holds the numeric constants.
 */
`default_nettype none

package pbas_pkg;
	typedef enum logic [2:0] {
		PBAS_SEL_NONE       = 3'b000,
		PBAS_SEL_PIN_LEVELS = 3'b001,
		PBAS_SEL_ANALOG     = 3'b010,
		PBAS_SEL_DIRECTION  = 3'b011,
		PBAS_SEL_OUT_VALUE  = 3'b100,
		PBAS_SEL_FUNCTION   = 3'b101,
		PBAS_SEL_SERIAL     = 3'b110,
		PBAS_SEL_STD_LEVELS = 3'b111
	} pbas_sel_t;
endpackage

`default_nettype wire

// ---- hdl/pbas_pin_buf.sv ----
/*
 * One standard I/O pin: output transistor enables and pull-up enable.
 * Assumes direction, value and function inputs come from registers.
 */
`include "pbas_cfg.svh"
`default_nettype none

module pbas_pin_buf #(
	parameter bit PULL_UP = 1'b0
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic dir,
	input  wire logic value,
	input  wire logic func_sel,
	input  wire logic periph_value,
	input  wire logic periph_oe,
	input  wire logic input_only,
	output var  logic high_en,
	output var  logic low_en,
	output var  logic pull_up_en
);
	wire drive_en;
	wire drive_val;

	// Peripheral with external clock never drives the pin
	assign drive_en  = func_sel ? (periph_oe & ~input_only) : dir;
	assign drive_val = func_sel ? periph_value : value;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_en    <= 1'b0;
			low_en     <= 1'b0;
			pull_up_en <= PULL_UP;
		end else begin
			high_en    <= drive_en & drive_val;
			low_en     <= drive_en & ~drive_val;
			pull_up_en <= PULL_UP;
		end
	end
endmodule

`default_nettype wire

// ---- hdl/pbas_axil_slave.sv ----
/*
 * AXI4-Lite slave front end: one write and one read at a time.
 * Assumes the parent decodes addresses combinationally and returns
 * read data and error flags in the same cycle.
 */
`include "pbas_cfg.svh"
`default_nettype none

module pbas_axil_slave (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [`PBAS_ADDR_W-1:0] awaddr,
	input  wire logic                    awvalid,
	output var  logic                    awready,
	input  wire logic [`PBAS_DATA_W-1:0] wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output var  logic                    wready,
	output var  logic [1:0]              bresp,
	output var  logic                    bvalid,
	input  wire logic                    bready,
	input  wire logic [`PBAS_ADDR_W-1:0] araddr,
	input  wire logic                    arvalid,
	output var  logic                    arready,
	output var  logic [`PBAS_DATA_W-1:0] rdata,
	output var  logic [1:0]              rresp,
	output var  logic                    rvalid,
	input  wire logic                    rready,
	output var  logic [`PBAS_ADDR_W-1:0] wr_addr,
	output var  logic [`PBAS_DATA_W-1:0] wr_data,
	output var  logic [3:0]              wr_strb,
	output logic                         wr_fire,
	input  wire logic                    wr_err,
	output logic                         rd_fire,
	input  wire logic [`PBAS_DATA_W-1:0] rd_data,
	input  wire logic                    rd_err
);
	logic have_aw;
	logic have_w;

	// Write happens once both halves are held and no answer is pending
	assign wr_fire = have_aw & have_w & ~bvalid;
	assign rd_fire = arvalid & arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= `PBAS_RESP_OKAY;
			have_aw <= 1'b0;
			have_w  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				wr_addr <= awaddr;
				awready <= 1'b0;
				have_aw <= 1'b1;
			end
			if (wvalid && wready) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
				wready  <= 1'b0;
				have_w  <= 1'b1;
			end
			if (wr_fire) begin
				bvalid  <= 1'b1;
				bresp   <= wr_err ? `PBAS_RESP_SLVERR : `PBAS_RESP_OKAY;
				have_aw <= 1'b0;
				have_w  <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `PBAS_RESP_OKAY;
		end else if (rd_fire) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_data;
			rresp   <= rd_err ? `PBAS_RESP_SLVERR : `PBAS_RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// ---- hdl/pbas_top.sv ----
/*
 * Port buffer and analog input select: one eight-pin standard I/O port
 * with direction, output value and peripheral function registers, and an
 * eight-pin input-only port whose pins go to general input or to the
 * analog converter. Registers sit behind an AXI4-Lite slave.
 * Assumes pin inputs are synchronous to aclk and that peripheral blocks
 * supply their output values and enables; serial clock modes come from the serial control register.
 */
`include "pbas_cfg.svh"
`default_nettype none

module pbas_top
	import pbas_pkg::*;
#(
	parameter logic [`PBAS_PORT_W-1:0] PULLUP_OPTION = `PBAS_PULLUP_OPTION
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [`PBAS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output var  logic                    s_axi_awready,
	input  wire logic [`PBAS_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output var  logic                    s_axi_wready,
	output var  logic [1:0]              s_axi_bresp,
	output var  logic                    s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`PBAS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output var  logic                    s_axi_arready,
	output var  logic [`PBAS_DATA_W-1:0] s_axi_rdata,
	output var  logic [1:0]              s_axi_rresp,
	output var  logic                    s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [`PBAS_PORT_W-1:0] input_port_pin,
	output var  logic [`PBAS_PORT_W-1:0] analog_route_bit,
	output var  logic [`PBAS_PORT_W-1:0] input_port_pull_up_en,
	input  wire logic [`PBAS_PORT_W-1:0] std_pin_in,
	output var  logic [`PBAS_PORT_W-1:0] std_pad_high_en,
	output var  logic [`PBAS_PORT_W-1:0] std_pad_low_en,
	output var  logic [`PBAS_PORT_W-1:0] std_pad_pull_up_en,
	input  wire logic [`PBAS_PORT_W-1:0] periph_out_value,
	input  wire logic [`PBAS_PORT_W-1:0] periph_out_en
);
	localparam int PW = `PBAS_PORT_W;

	logic [PW-1:0]             analog_channel_select;
	logic [PW-1:0]             pin_direction_reg;
	logic [PW-1:0]             pin_output_value_reg;
	logic [PW-1:0]             pin_function_reg;
	logic [1:0]                serial_ext_clock;
	logic [`PBAS_ADDR_W-1:0]   wr_addr;
	logic [`PBAS_DATA_W-1:0]   wr_data;
	logic [3:0]                wr_strb;
	logic                      wr_fire;
	logic                      rd_fire;
	logic [`PBAS_DATA_W-1:0]   rd_data;
	pbas_sel_t                 wr_sel;
	pbas_sel_t                 rd_sel;
	logic                      wr_en;
	logic [PW-1:0]             wr_byte;
	logic [PW-1:0]             input_port_pin_levels;
	logic [PW-1:0]             std_port_levels;
	logic [PW-1:0]             input_only_pin;
	logic [PW-1:0]             rd_byte;

	function automatic pbas_sel_t reg_decode(input logic [`PBAS_ADDR_W-1:0] addr);
		logic [15:0] idx;
		idx = addr[`PBAS_ADDR_W-1:2];
		unique case (idx)
			`PBAS_IDX_PIN_LEVELS:  reg_decode = PBAS_SEL_PIN_LEVELS;
			`PBAS_IDX_ANALOG_SEL:  reg_decode = PBAS_SEL_ANALOG;
			`PBAS_IDX_DIRECTION:   reg_decode = PBAS_SEL_DIRECTION;
			`PBAS_IDX_OUT_VALUE:   reg_decode = PBAS_SEL_OUT_VALUE;
			`PBAS_IDX_FUNCTION:    reg_decode = PBAS_SEL_FUNCTION;
			`PBAS_IDX_SERIAL_CTRL: reg_decode = PBAS_SEL_SERIAL;
			`PBAS_IDX_STD_LEVELS:  reg_decode = PBAS_SEL_STD_LEVELS;
			default:               reg_decode = PBAS_SEL_NONE;
		endcase
	endfunction

	pbas_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_fire (wr_fire),
		.wr_err  (wr_sel == PBAS_SEL_NONE),
		.rd_fire (rd_fire),
		.rd_data (rd_data),
		.rd_err  (rd_sel == PBAS_SEL_NONE)
	);

	assign wr_sel  = reg_decode(wr_addr);
	assign rd_sel  = reg_decode(s_axi_araddr);
	// Registers hold up to eight bits in the low lane only
	assign wr_en   = wr_fire & wr_strb[0];
	assign wr_byte = wr_data[PW-1:0];

	// Analog pins read as 1, general inputs give the live level
	assign input_port_pin_levels = input_port_pin | analog_channel_select;
	// Output pins in port function return stored data, the rest the pin
	assign std_port_levels = (pin_direction_reg & ~pin_function_reg & pin_output_value_reg)
		| (~(pin_direction_reg & ~pin_function_reg) & std_pin_in);

	// Analog select is write-only and reads as zero
	assign rd_byte = (rd_sel == PBAS_SEL_PIN_LEVELS) ? input_port_pin_levels :
		(rd_sel == PBAS_SEL_DIRECTION)  ? pin_direction_reg :
		(rd_sel == PBAS_SEL_OUT_VALUE)  ? pin_output_value_reg :
		(rd_sel == PBAS_SEL_FUNCTION)   ? pin_function_reg :
		(rd_sel == PBAS_SEL_SERIAL)     ? {6'h00, serial_ext_clock} :
		(rd_sel == PBAS_SEL_STD_LEVELS) ? std_port_levels : 8'h00;
	assign rd_data = {24'h000000, rd_byte};

	// Writes to the pin level register fall through with no effect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_channel_select <= `PBAS_RST_ANALOG_SEL;
			pin_direction_reg     <= `PBAS_RST_DIRECTION;
			pin_output_value_reg  <= `PBAS_RST_OUT_VALUE;
			pin_function_reg      <= `PBAS_RST_FUNCTION;
			serial_ext_clock      <= `PBAS_RST_SERIAL_CTRL;
		end else if (wr_en) begin
			if (wr_sel == PBAS_SEL_ANALOG)
				analog_channel_select <= wr_byte;
			if (wr_sel == PBAS_SEL_DIRECTION)
				pin_direction_reg <= wr_byte;
			if (wr_sel == PBAS_SEL_OUT_VALUE)
				pin_output_value_reg <= wr_byte;
			if (wr_sel == PBAS_SEL_FUNCTION)
				pin_function_reg <= wr_byte;
			if (wr_sel == PBAS_SEL_SERIAL)
				serial_ext_clock <= wr_byte[1:0];
		end
	end

	// Converter routing and the input-only port's absent pull-ups
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_route_bit      <= `PBAS_RST_ANALOG_SEL;
			input_port_pull_up_en <= 8'h00;
		end else begin
			analog_route_bit      <= analog_channel_select;
			input_port_pull_up_en <= 8'h00;
		end
	end

	// Serial clock pins in external clock mode become input-only while handed to the serial block
	always_comb begin
		input_only_pin                = 8'h00;
		input_only_pin[`PBAS_SER_CLK1_POS] = serial_ext_clock[`PBAS_SER_EXT1_BIT];
		input_only_pin[`PBAS_SER_CLK2_POS] = serial_ext_clock[`PBAS_SER_EXT2_BIT];
	end

	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++) begin : g_pin
			pbas_pin_buf #(
				.PULL_UP (PULLUP_OPTION[gi])
			) u_pin (
				.aclk         (aclk),
				.aresetn      (aresetn),
				.dir          (pin_direction_reg[gi]),
				.value        (pin_output_value_reg[gi]),
				.func_sel     (pin_function_reg[gi]),
				.periph_value (periph_out_value[gi]),
				.periph_oe    (periph_out_en[gi]),
				.input_only   (input_only_pin[gi]),
				.high_en      (std_pad_high_en[gi]),
				.low_en       (std_pad_low_en[gi]),
				.pull_up_en   (std_pad_pull_up_en[gi])
			);
		end
	endgenerate

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_reset_clear;
		$rose(aresetn) |-> (analog_channel_select == 8'h00) && (pin_direction_reg == 8'h00)
			&& (pin_function_reg == 8'h00) && (pin_output_value_reg == 8'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("registers not cleared by reset");

	property p_dir_off;
		(pin_direction_reg == 8'h00) && (pin_function_reg == 8'h00)
			|=> (std_pad_high_en == 8'h00) && (std_pad_low_en == 8'h00);
	endproperty
	a_dir_off: assert property (p_dir_off)
		else $error("pad driven with direction cleared");

	property p_drive_value;
		(pin_function_reg == 8'h00) |=>
			(std_pad_high_en == ($past(pin_direction_reg) & $past(pin_output_value_reg)))
			&& (std_pad_low_en == ($past(pin_direction_reg) & ~$past(pin_output_value_reg)));
	endproperty
	a_drive_value: assert property (p_drive_value)
		else $error("pad transistors do not follow data bit");

	property p_pull_up_fixed;
		std_pad_pull_up_en == PULLUP_OPTION;
	endproperty
	a_pull_up_fixed: assert property (p_pull_up_fixed)
		else $error("standard pull-up departs from build option");

	property p_no_input_pull_up;
		input_port_pull_up_en == 8'h00;
	endproperty
	a_no_input_pull_up: assert property (p_no_input_pull_up)
		else $error("input-only port pull-up enabled");

	// Only a pin handed to the serial block is affected; a plain port pin may drive
	property p_sck_undriven;
		serial_ext_clock[`PBAS_SER_EXT1_BIT] && pin_function_reg[`PBAS_SER_CLK1_POS] |=>
			!std_pad_high_en[`PBAS_SER_CLK1_POS] && !std_pad_low_en[`PBAS_SER_CLK1_POS];
	endproperty
	a_sck_undriven: assert property (p_sck_undriven)
		else $error("external serial clock pin driven");

	property p_serial_clock_pin_two_undriven;
		serial_ext_clock[`PBAS_SER_EXT2_BIT] && pin_function_reg[`PBAS_SER_CLK2_POS] |=>
			!std_pad_high_en[`PBAS_SER_CLK2_POS] && !std_pad_low_en[`PBAS_SER_CLK2_POS];
	endproperty
	a_serial_clock_pin_two_undriven: assert property (p_serial_clock_pin_two_undriven)
		else $error("second external serial clock pin driven");

	sequence s_analog_read;
		rd_fire && (rd_sel == PBAS_SEL_ANALOG);
	endsequence
	property p_analog_reads_zero;
		s_analog_read |=> s_axi_rvalid && (s_axi_rdata == 32'h00000000);
	endproperty
	a_analog_reads_zero: assert property (p_analog_reads_zero)
		else $error("write-only analog select read back non-zero");

	property p_level_write_ignored;
		wr_en && (wr_sel == PBAS_SEL_PIN_LEVELS) |=> $stable(analog_channel_select)
			&& $stable(pin_direction_reg) && $stable(pin_output_value_reg)
			&& $stable(pin_function_reg) && $stable(serial_ext_clock);
	endproperty
	a_level_write_ignored: assert property (p_level_write_ignored)
		else $error("write to pin level register changed a register");

	sequence s_analog_write;
		wr_en && (wr_sel == PBAS_SEL_ANALOG);
	endsequence
	property p_analog_write;
		s_analog_write |=> (analog_channel_select == $past(wr_byte))
			##1 (analog_route_bit == $past(analog_channel_select));
	endproperty
	a_analog_write: assert property (p_analog_write)
		else $error("analog select write not taken or not routed");

	property p_route_follows;
		##1 (analog_route_bit == $past(analog_channel_select));
	endproperty
	a_route_follows: assert property (p_route_follows)
		else $error("converter routing lags select register");

	sequence s_level_read;
		rd_fire && (rd_sel == PBAS_SEL_PIN_LEVELS);
	endsequence
	property p_level_read;
		s_level_read |=> s_axi_rvalid
			&& (s_axi_rdata == {24'h000000, $past(input_port_pin | analog_channel_select)});
	endproperty
	a_level_read: assert property (p_level_read)
		else $error("input level read returns wrong value");

	property p_std_read;
		rd_fire && (rd_sel == PBAS_SEL_STD_LEVELS) && (pin_function_reg == 8'h00)
			|=> s_axi_rdata[7:0] == (($past(pin_direction_reg) & $past(pin_output_value_reg))
			| (~$past(pin_direction_reg) & $past(std_pin_in)));
	endproperty
	a_std_read: assert property (p_std_read)
		else $error("standard port read returns wrong value");
endmodule

`default_nettype wire

// ---- dv/pbas_ext_pins.sv ----
/*
 * Outside circuitry on the standard port: each pin level is resolved
 * from the device pads, an outside source and the pull-up.
 * Assumes pad enables come straight from the block under test.
 */
`default_nettype none

module pbas_ext_pins (
	input  wire logic       aclk,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] high_en,
	input  wire logic [7:0] low_en,
	input  wire logic [7:0] pull_up_en,
	output var  logic [7:0] std_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] churn = 8'h00;
	// Floating pins wander, so a stale level never passes for a real one
	always @(posedge aclk)
		churn <= ~churn;
	always_comb
		for (int i = 0; i < 8; i++)
			std_pin_in[i] = high_en[i] ? 1'b1 : low_en[i] ? 1'b0 :
				ext_en[i] ? ext_val[i] : pull_up_en[i] ? 1'b1 : churn[i];
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
/*
 * Self-checking bench: register traffic over AXI4-Lite, pad enables
 * and pin levels compared against values worked out here.
 * Assumes pbas_pkg and the design files are compiled first.
 */
`include "pbas_cfg.svh"
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PULL = 8'hA5;
	localparam logic [1:0] OK = `PBAS_RESP_OKAY;
	localparam logic [1:0] ERR = `PBAS_RESP_SLVERR;
	typedef struct {logic [1:0] resp; logic [31:0] data;} pbas_exp_t;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ser;
	logic [7:0]  input_port_pin = '0, periph_out_value = '0, periph_out_en = '0;
	logic [7:0]  ext_val = '0, ext_en = 8'hFF, std_pin_in;
	logic [7:0]  analog_route_bit, input_port_pull_up_en;
	logic [7:0]  std_pad_high_en, std_pad_low_en, std_pad_pull_up_en;
	logic [7:0]  dir, val, fn, sel, pins, hi, lo, gen, per, sk, ee, lvl;
	logic [1:0]  qb[$], eb;
	pbas_exp_t   qr[$], er;
	int          miscompares = 0, n_checks = 0;

	always #2.5 aclk = ~aclk;

	pbas_top #(.PULLUP_OPTION(PULL)) u_dut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .input_port_pin, .analog_route_bit,
		.input_port_pull_up_en, .std_pin_in, .std_pad_high_en, .std_pad_low_en,
		.std_pad_pull_up_en, .periph_out_value, .periph_out_en);

	pbas_ext_pins u_pins (.aclk, .ext_val, .ext_en, .high_en(std_pad_high_en),
		.low_en(std_pad_low_en), .pull_up_en(std_pad_pull_up_en), .std_pin_in);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic hang_out(input string name);
		miscompares++;
		$display("BAD %s expected answer seen none", name);
		report_and_stop();
	endtask

	task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] resp);
		int i;
		@(posedge aclk);
		qb.push_back(resp);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (i == 50) hang_out("bvalid");
	endtask

	task automatic axi_rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] resp);
		int i;
		@(posedge aclk);
		qr.push_back('{resp, {24'h0, d}});
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 50) hang_out("rvalid");
	endtask

	// Answers are matched in order against the oldest note
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			eb = qb.pop_front();
			check("bresp", 32'(s_axi_bresp), 32'(eb));
		end
		if (s_axi_rvalid && s_axi_rready) begin
			er = qr.pop_front();
			check("rresp", 32'(s_axi_rresp), 32'(er.resp));
			// Error answers carry no defined data
			if (er.resp === OK) check("rdata", s_axi_rdata, er.data);
		end
	end

	task automatic reset_state;
		check("high", 32'(std_pad_high_en), 32'h0);
		check("low", 32'(std_pad_low_en), 32'h0);
		check("pull", 32'(std_pad_pull_up_en), 32'(PULL));
		check("in_pull", 32'(input_port_pull_up_en), 32'h0);
		check("route", 32'(analog_route_bit), 32'h0);
	endtask

	initial begin
		void'($urandom(98));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reset_state();
		for (int k = 0; k < 6; k++) begin
			sel = (k == 0) ? 8'hFF : 8'($urandom);
			pins = 8'($urandom);
			input_port_pin <= pins;
			axi_wr(`PBAS_IDX_ANALOG_SEL, sel, OK);
			axi_wr(`PBAS_IDX_PIN_LEVELS, ~pins, OK);
			axi_rd(`PBAS_IDX_PIN_LEVELS, pins | sel, OK);
			axi_rd(`PBAS_IDX_ANALOG_SEL, 8'h00, OK);
			check("route", 32'(analog_route_bit), 32'(sel));
		end
		axi_wr(16'h0000, 8'h5A, ERR);
		axi_rd(16'h0001, 8'h00, ERR);
		for (int k = 0; k < 8; k++) begin
			dir = 8'($urandom);
			val = 8'($urandom);
			fn = (k == 0) ? 8'h12 : (k == 1) ? 8'h00 : 8'($urandom);
			ser = (k == 0) ? 2'h3 : 2'($urandom);
			periph_out_en <= (k == 0) ? 8'hFF : 8'($urandom);
			periph_out_value <= 8'($urandom);
			ext_val <= 8'($urandom);
			// Outside source lets go only where the pull-up holds the pin
			ee = 8'($urandom) | ~PULL;
			ext_en <= ee;
			axi_wr(`PBAS_IDX_DIRECTION, dir, OK);
			axi_wr(`PBAS_IDX_OUT_VALUE, val, OK);
			axi_wr(`PBAS_IDX_FUNCTION, fn, OK);
			axi_wr(`PBAS_IDX_SERIAL_CTRL, {6'h0, ser}, OK);
			sk = (8'(ser[0]) << `PBAS_SER_CLK1_POS) | (8'(ser[1]) << `PBAS_SER_CLK2_POS);
			gen = dir & ~fn;
			per = fn & periph_out_en & ~sk;
			hi = gen & val | per & periph_out_value;
			lo = gen & ~val | per & ~periph_out_value;
			repeat (2) @(posedge aclk);
			check("high", 32'(std_pad_high_en), 32'(hi));
			check("low", 32'(std_pad_low_en), 32'(lo));
			check("pull", 32'(std_pad_pull_up_en), 32'(PULL));
			lvl = gen & val | ~gen & (hi | ~lo & (ee & ext_val | ~ee));
			axi_rd(`PBAS_IDX_STD_LEVELS, lvl, OK);
		end
		// Second reset in mid-run must drop every selection
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reset_state();
		axi_rd(`PBAS_IDX_PIN_LEVELS, pins, OK);
		axi_rd(`PBAS_IDX_DIRECTION, 8'h00, OK);
		// Low byte lane off: the write is answered but lands nowhere
		s_axi_wstrb <= 4'hE;
		axi_wr(`PBAS_IDX_DIRECTION, 8'hFF, OK);
		s_axi_wstrb <= 4'hF;
		axi_rd(`PBAS_IDX_DIRECTION, 8'h00, OK);
		report_and_stop();
	end
endmodule

`default_nettype wire
